// File: rtl/clk_sysref_cfg_regs.sv
/*
 * Clock and SYSREF configuration register slice with its serial register
 * port. The port pins are sampled on ref_clk; a frame is a direction bit
 * (one for read), a 15-bit address, then data bytes with the address
 * stepping up by one after each byte.
 * Assumes the serial clock is slower than ref_clk by at least four times,
 * that the pins are synchronous to ref_clk, and that data is sent MSB first.
 */
`timescale 1ns/1ps
`default_nettype none
module clk_sysref_cfg_regs #(
    parameter int SAMPLE_W = 12,
    parameter int POS_W = 24
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spi_csn,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    input wire logic [POS_W-1:0] detector_position,
    input wire logic sample_marking_enable,
    input wire logic decimation_bypass,
    input wire logic sysref_level,
    input wire logic [SAMPLE_W-1:0] sample_in,
    output logic [SAMPLE_W-1:0] sample_out,
    output logic sysref_aligned,
    output logic sysref_marker_enable,
    output logic device_clock_pecl_mode,
    output logic sysref_pecl_mode,
    output logic sysref_polarity_invert,
    output logic feedback_gain_high,
    output logic supply_noise_suppress,
    output logic [1:0] sample_clock_delay,
    output logic [15:0] fullscale_range_chan_a
);
    clk_sysref_cfg_pkg::frame_state_e state_reg;
    logic sclk_prev_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic [4:0] hdr_cnt_reg;
    logic [3:0] bit_cnt_reg;
    logic [15:0] hdr_shift_reg;
    logic [15:0] hdr_next;
    logic [7:0] data_shift_reg;
    logic [7:0] data_next;
    logic [7:0] out_shift_reg;
    logic read_frame_reg;
    logic [clk_sysref_cfg_pkg::ADDR_W-1:0] addr_reg;
    logic [clk_sysref_cfg_pkg::ADDR_W-1:0] rd_addr;
    logic hdr_done;
    logic byte_done;
    logic wr_stb;
    logic [7:0] rdata;
    logic freeze;
    logic [7:0] clk_input_ctrl_reg;
    logic [7:0] sample_clk_tune_reg;
    logic [15:0] fullscale_range_chan_a_reg;
    logic [POS_W-1:0] live_position;
    logic [POS_W-1:0] frozen_position;

    marker_cfg_if cfg_bus ();

    // Serial clock edges seen at ref_clk rate.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= spi_sclk;
        end
    end

    assign sclk_rise = spi_sclk && !sclk_prev_reg && !spi_csn;
    assign sclk_fall = !spi_sclk && sclk_prev_reg && !spi_csn;
    assign hdr_next = {hdr_shift_reg[14:0], spi_sdi};
    assign data_next = {data_shift_reg[6:0], spi_sdi};
    assign hdr_done = (state_reg == clk_sysref_cfg_pkg::FRAME_HEADER) && sclk_rise
        && (hdr_cnt_reg == clk_sysref_cfg_pkg::HDR_LAST - 5'h01);
    assign byte_done = (state_reg == clk_sysref_cfg_pkg::FRAME_DATA) && sclk_rise
        && (bit_cnt_reg == clk_sysref_cfg_pkg::BYTE_LAST - 4'h1);
    assign wr_stb = byte_done && !read_frame_reg;

    // Address used for the read byte that is about to be loaded.
    always_comb begin
        if (hdr_done) begin
            rd_addr = hdr_next[clk_sysref_cfg_pkg::ADDR_W-1:0];
        end else begin
            rd_addr = addr_reg + clk_sysref_cfg_pkg::ADDR_STEP;
        end
    end

    // Frame sequencing: chip select high returns to idle at once.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg <= clk_sysref_cfg_pkg::FRAME_IDLE;
        end else if (spi_csn) begin
            state_reg <= clk_sysref_cfg_pkg::FRAME_IDLE;
        end else begin
            unique case (state_reg)
                clk_sysref_cfg_pkg::FRAME_IDLE: begin
                    state_reg <= clk_sysref_cfg_pkg::FRAME_HEADER;
                end
                clk_sysref_cfg_pkg::FRAME_HEADER: begin
                    if (hdr_done) begin
                        state_reg <= clk_sysref_cfg_pkg::FRAME_DATA;
                    end
                end
                clk_sysref_cfg_pkg::FRAME_DATA: begin
                    state_reg <= clk_sysref_cfg_pkg::FRAME_DATA;
                end
            endcase
        end
    end

    // Header shift and bit count.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hdr_shift_reg <= 16'h0000;
            hdr_cnt_reg <= 5'h00;
        end else if (state_reg != clk_sysref_cfg_pkg::FRAME_HEADER) begin
            hdr_cnt_reg <= 5'h00;
        end else if (sclk_rise) begin
            hdr_shift_reg <= hdr_next;
            hdr_cnt_reg <= hdr_cnt_reg + 5'h01;
        end
    end

    // Direction and streaming address.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            read_frame_reg <= 1'b0;
            addr_reg <= '0;
        end else if (hdr_done) begin
            read_frame_reg <= hdr_next[clk_sysref_cfg_pkg::HDR_RW_BIT];
            addr_reg <= hdr_next[clk_sysref_cfg_pkg::ADDR_W-1:0];
        end else if (byte_done) begin
            addr_reg <= addr_reg + clk_sysref_cfg_pkg::ADDR_STEP;
        end
    end

    // Data byte shift and count within the byte.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            data_shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
        end else if (state_reg != clk_sysref_cfg_pkg::FRAME_DATA) begin
            bit_cnt_reg <= 4'h0;
        end else if (byte_done) begin
            data_shift_reg <= data_next;
            bit_cnt_reg <= 4'h0;
        end else if (sclk_rise) begin
            data_shift_reg <= data_next;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // Read byte: loaded after the header and after each byte, shifted on
    // falling edges once the master has sampled the current bit.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_shift_reg <= 8'h00;
        end else if (hdr_done || byte_done) begin
            out_shift_reg <= rdata;
        end else if (sclk_fall && (state_reg == clk_sysref_cfg_pkg::FRAME_DATA)
                && (bit_cnt_reg != 4'h0)) begin
            out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        end
    end

    // Serial output driven only during the data phase of a read.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            spi_sdo_oe_n <= 1'b1;
        end else begin
            spi_sdo_oe_n <= !((state_reg == clk_sysref_cfg_pkg::FRAME_DATA) && read_frame_reg
                && !spi_csn);
        end
    end

    assign spi_sdo = out_shift_reg[7];

    // Register read mux; unmapped addresses return zero.
    always_comb begin
        unique case (rd_addr)
            clk_sysref_cfg_pkg::ADDR_CLK_INPUT_CTRL: rdata = clk_input_ctrl_reg;
            clk_sysref_cfg_pkg::ADDR_SAMPLE_CLK_TUNE: rdata = sample_clk_tune_reg;
            clk_sysref_cfg_pkg::ADDR_EDGE_POS_0: rdata = live_position[7:0];
            clk_sysref_cfg_pkg::ADDR_EDGE_POS_1: rdata = frozen_position[15:8];
            clk_sysref_cfg_pkg::ADDR_EDGE_POS_2: rdata = frozen_position[23:16];
            clk_sysref_cfg_pkg::ADDR_FULLSCALE_RANGE_CHAN_A_0: rdata = fullscale_range_chan_a_reg[7:0];
            clk_sysref_cfg_pkg::ADDR_FULLSCALE_RANGE_CHAN_A_1: rdata = fullscale_range_chan_a_reg[15:8];
            default: rdata = clk_sysref_cfg_pkg::READ_UNMAPPED;
        endcase
    end

    // The snapshot is taken when the low position byte is loaded for reading.
    assign freeze = (hdr_done || byte_done) && (rd_addr == clk_sysref_cfg_pkg::ADDR_EDGE_POS_0);

    // Clock input control register, reserved bits stored as written.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clk_input_ctrl_reg <= clk_sysref_cfg_pkg::RST_CLK_INPUT_CTRL;
        end else if (wr_stb && (addr_reg == clk_sysref_cfg_pkg::ADDR_CLK_INPUT_CTRL)) begin
            clk_input_ctrl_reg <= data_next;
        end
    end

    // Sampling clock tuning register; delay code is stored as written.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sample_clk_tune_reg <= clk_sysref_cfg_pkg::RST_SAMPLE_CLK_TUNE;
        end else if (wr_stb && (addr_reg == clk_sysref_cfg_pkg::ADDR_SAMPLE_CLK_TUNE)) begin
            sample_clk_tune_reg <= data_next;
        end
    end

    // Channel A full-scale range, written one byte at a time.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fullscale_range_chan_a_reg <= clk_sysref_cfg_pkg::RST_FULLSCALE_RANGE_CHAN_A;
        end else if (wr_stb && (addr_reg == clk_sysref_cfg_pkg::ADDR_FULLSCALE_RANGE_CHAN_A_0)) begin
            fullscale_range_chan_a_reg[7:0] <= data_next;
        end else if (wr_stb && (addr_reg == clk_sysref_cfg_pkg::ADDR_FULLSCALE_RANGE_CHAN_A_1)) begin
            fullscale_range_chan_a_reg[15:8] <= data_next;
        end
    end

    // Configuration outputs decoded from the stored fields.
    assign sysref_marker_enable = clk_input_ctrl_reg[clk_sysref_cfg_pkg::BIT_SYSREF_MARKER];
    assign device_clock_pecl_mode = clk_input_ctrl_reg[clk_sysref_cfg_pkg::BIT_DEVCLK_PECL];
    assign sysref_pecl_mode = clk_input_ctrl_reg[clk_sysref_cfg_pkg::BIT_SYSREF_PECL];
    assign sysref_polarity_invert = clk_input_ctrl_reg[clk_sysref_cfg_pkg::BIT_SYSREF_INVERT];
    assign feedback_gain_high = sample_clk_tune_reg[clk_sysref_cfg_pkg::BIT_FEEDBACK_GAIN];
    assign supply_noise_suppress = sample_clk_tune_reg[clk_sysref_cfg_pkg::BIT_NOISE_SUPPRESS];
    assign sample_clock_delay = sample_clk_tune_reg[clk_sysref_cfg_pkg::DELAY_MSB:
        clk_sysref_cfg_pkg::DELAY_LSB];
    assign fullscale_range_chan_a = fullscale_range_chan_a_reg;

    // Marking configuration travels to the sample stage over the interface.
    assign cfg_bus.sysref_marker_enable = sysref_marker_enable;
    assign cfg_bus.sysref_polarity_invert = sysref_polarity_invert;

    edge_position_hold #(
        .POS_W(POS_W)
    ) u_pos (
        .ref_clk(ref_clk),
        .rst(rst),
        .detector_position(detector_position),
        .freeze(freeze),
        .live_position(live_position),
        .frozen_position(frozen_position)
    );

    sample_marker #(
        .SAMPLE_W(SAMPLE_W)
    ) u_marker (
        .ref_clk(ref_clk),
        .rst(rst),
        .cfg(cfg_bus),
        .sample_marking_enable(sample_marking_enable),
        .decimation_bypass(decimation_bypass),
        .sysref_level(sysref_level),
        .sample_in(sample_in),
        .sample_out(sample_out),
        .sysref_aligned(sysref_aligned)
    );
endmodule
`default_nettype wire

// File: rtl/clk_sysref_cfg_pkg.sv
/*
 * Constants for the clock and SYSREF configuration register slice: register
 * addresses, field positions, reset values and serial frame layout.
 * Assumes nothing of its surroundings; the register slice and the edge position holder use it by scope.
 */
// Functional notes
// - Timestamp and sample marking both set put SYSREF level on each sample LSB.
// - Marking only valid with decimation bypassed (D=1); not applied otherwise.
// - Clock control bit 2 selects DC-coupled PECL mode of device clock receiver.
// - Clock control bit 1 selects DC-coupled PECL mode of SYSREF receiver.
// - Clock control bit 0 inverts SYSREF before alignment use.
// - Tuning bit 4 selects clock converter feedback gain, one is high, resets one.
// - Tuning bit 2 enables analog clock supply noise suppression, resets zero.
// - Tuning bits 1:0 one-hot sample clock delay, reset 0x1, software writes one-hot.
// - A 24-bit status field reports SYSREF edge position against device clock.
// - Channel A full-scale range register is 16 bits, resets to 0xA000.
// - Sampling clock tuning register resets to 0x11.
// - Range code 0x2000 is 500 mVpp, 0xA000 800 mVpp, 0xFFFF 1000 mVpp.
package clk_sysref_cfg_pkg;

    // Serial frame layout: one direction bit, a 15-bit address, then data bytes.
    localparam int ADDR_W = 15;
    localparam int HDR_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam logic [4:0] HDR_LAST = 5'h10;
    localparam logic [3:0] BYTE_LAST = 4'h8;
    localparam int HDR_RW_BIT = 15;

    // Register byte addresses; multi-byte registers put the low byte first.
    localparam logic [ADDR_W-1:0] ADDR_CLK_INPUT_CTRL = 15'h002A;
    localparam logic [ADDR_W-1:0] ADDR_SAMPLE_CLK_TUNE = 15'h002B;
    localparam logic [ADDR_W-1:0] ADDR_EDGE_POS_0 = 15'h002C;
    localparam logic [ADDR_W-1:0] ADDR_EDGE_POS_1 = 15'h002D;
    localparam logic [ADDR_W-1:0] ADDR_EDGE_POS_2 = 15'h002E;
    localparam logic [ADDR_W-1:0] ADDR_FULLSCALE_RANGE_CHAN_A_0 = 15'h0030;
    localparam logic [ADDR_W-1:0] ADDR_FULLSCALE_RANGE_CHAN_A_1 = 15'h0031;
    localparam logic [ADDR_W-1:0] ADDR_STEP = 15'h0001;

    // Reset values.
    localparam logic [7:0] RST_CLK_INPUT_CTRL = 8'h00;
    localparam logic [7:0] RST_SAMPLE_CLK_TUNE = 8'h11;
    localparam logic [23:0] RST_EDGE_POS = 24'h000000;
    localparam logic [15:0] RST_FULLSCALE_RANGE_CHAN_A = 16'hA000;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Clock input control fields.
    localparam int BIT_SYSREF_MARKER = 3;
    localparam int BIT_DEVCLK_PECL = 2;
    localparam int BIT_SYSREF_PECL = 1;
    localparam int BIT_SYSREF_INVERT = 0;

    // Sampling clock tuning fields.
    localparam int BIT_FEEDBACK_GAIN = 4;
    localparam int BIT_NOISE_SUPPRESS = 2;
    localparam int DELAY_MSB = 1;
    localparam int DELAY_LSB = 0;

    // Full-scale range code landmarks.
    localparam logic [15:0] FS_CODE_MIN_RECOMMENDED = 16'h2000;
    localparam logic [15:0] FS_CODE_DEFAULT = 16'hA000;
    localparam logic [15:0] FS_CODE_MAX = 16'hFFFF;

    typedef enum logic [1:0] {
        FRAME_IDLE,
        FRAME_HEADER,
        FRAME_DATA
    } frame_state_e;

endpackage

// File: rtl/marker_cfg_if.sv
/*
 * Interface carrying the timestamp marking configuration from the register
 * slice to the sample marking stage.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
interface marker_cfg_if;
    logic sysref_marker_enable;
    logic sysref_polarity_invert;

    modport regs (output sysref_marker_enable, output sysref_polarity_invert);
    modport marker (input sysref_marker_enable, input sysref_polarity_invert);
endinterface
`default_nettype wire

// File: rtl/sample_marker.sv
/*
 * Sample marking stage: applies SYSREF polarity and, when allowed, replaces
 * the least significant bit of each output sample with the SYSREF level.
 * Assumes samples and SYSREF level are synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module sample_marker #(
    parameter int SAMPLE_W = 12
) (
    input wire logic ref_clk,
    input wire logic rst,
    marker_cfg_if.marker cfg,
    input wire logic sample_marking_enable,
    input wire logic decimation_bypass,
    input wire logic sysref_level,
    input wire logic [SAMPLE_W-1:0] sample_in,
    output logic [SAMPLE_W-1:0] sample_out,
    output logic sysref_aligned
);
    logic sysref_used;
    logic mark_active;

    // Polarity applies before the level is used for alignment or marking.
    assign sysref_used = sysref_level ^ cfg.sysref_polarity_invert;
    // Marking needs both enables and the undecimated path.
    assign mark_active = cfg.sysref_marker_enable && sample_marking_enable
        && decimation_bypass;

    // Registered sample output with optional LSB replacement.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sample_out <= '0;
        end else if (mark_active) begin
            sample_out <= {sample_in[SAMPLE_W-1:1], sysref_used};
        end else begin
            sample_out <= sample_in;
        end
    end

    // Registered aligned SYSREF for the alignment logic.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sysref_aligned <= 1'b0;
        end else begin
            sysref_aligned <= sysref_used;
        end
    end
endmodule
`default_nettype wire

// File: rtl/edge_position_hold.sv
/*
 * Holder for the SYSREF edge position status: tracks the detector every
 * cycle and freezes a copy when a read of the low byte begins.
 * Assumes the detector result is synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module edge_position_hold #(
    parameter int POS_W = 24
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [POS_W-1:0] detector_position,
    input wire logic freeze,
    output logic [POS_W-1:0] live_position,
    output logic [POS_W-1:0] frozen_position
);
    // Latest detector result; no register write path exists here.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            live_position <= clk_sysref_cfg_pkg::RST_EDGE_POS;
        end else begin
            live_position <= detector_position;
        end
    end

    // Snapshot so the three bytes of one read belong together.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frozen_position <= clk_sysref_cfg_pkg::RST_EDGE_POS;
        end else if (freeze) begin
            frozen_position <= live_position;
        end
    end
endmodule
`default_nettype wire

// File: tb/cfg_regs_checker.sv
/*
 * Checker for the clock and SYSREF configuration register slice.
 * Assumes it is bound to the slice's top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_checker #(
    parameter int SAMPLE_W = 12,
    parameter int POS_W = 24
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic spi_csn,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    input wire logic spi_sdo,
    input wire logic spi_sdo_oe_n,
    input wire logic [POS_W-1:0] detector_position,
    input wire logic sample_marking_enable,
    input wire logic decimation_bypass,
    input wire logic sysref_level,
    input wire logic [SAMPLE_W-1:0] sample_in,
    input wire logic [SAMPLE_W-1:0] sample_out,
    input wire logic sysref_aligned,
    input wire logic sysref_marker_enable,
    input wire logic device_clock_pecl_mode,
    input wire logic sysref_pecl_mode,
    input wire logic sysref_polarity_invert,
    input wire logic feedback_gain_high,
    input wire logic supply_noise_suppress,
    input wire logic [1:0] sample_clock_delay,
    input wire logic [15:0] fullscale_range_chan_a
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Marking is active only with all three enables set.
    sequence marking_on;
        sysref_marker_enable && sample_marking_enable && decimation_bypass;
    endsequence
    sequence marking_off;
        !(sysref_marker_enable && sample_marking_enable && decimation_bypass);
    endsequence

    a_marker_lsb: assert property (marking_on |=>
        sample_out[0] == $past(sysref_level ^ sysref_polarity_invert))
        else $error("marked sample LSB does not carry SYSREF level");
    a_marker_upper: assert property (marking_on |=>
        sample_out[SAMPLE_W-1:1] == $past(sample_in[SAMPLE_W-1:1]))
        else $error("marked sample upper bits corrupted");
    a_bypass_pass: assert property (marking_off |=> sample_out == $past(sample_in))
        else $error("unmarked sample altered");
    a_align_invert: assert property (1'b1 |=>
        sysref_aligned == $past(sysref_level ^ sysref_polarity_invert))
        else $error("aligned SYSREF polarity wrong");
    a_range_reset: assert property ($past(rst) |-> fullscale_range_chan_a == 16'hA000)
        else $error("range default wrong after reset");
    a_tune_reset: assert property ($past(rst) |->
        {feedback_gain_high, supply_noise_suppress, sample_clock_delay} == 4'h9)
        else $error("tuning default wrong after reset");
    a_ctrl_reset: assert property ($past(rst) |-> {sysref_marker_enable,
        device_clock_pecl_mode, sysref_pecl_mode, sysref_polarity_invert} == 4'h0)
        else $error("clock control default wrong after reset");
    a_range_framed: assert property (!$stable(fullscale_range_chan_a) |-> !$past(spi_csn))
        else $error("range changed outside a frame");
    a_tune_framed: assert property (!$stable(sample_clock_delay) |-> !$past(spi_csn))
        else $error("delay changed outside a frame");
    // The serial output stays released whenever no frame was open at the last edge.
    a_sdo_released: assert property ($past(spi_csn) |-> spi_sdo_oe_n)
        else $error("serial output enabled outside a frame");
    c_marking: cover property (marking_on);
endmodule

bind clk_sysref_cfg_regs cfg_regs_checker #(.SAMPLE_W(SAMPLE_W), .POS_W(POS_W)) chk_u (
    .ref_clk(ref_clk), .rst(rst), .spi_csn(spi_csn), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
    .detector_position(detector_position), .sample_marking_enable(sample_marking_enable),
    .decimation_bypass(decimation_bypass), .sysref_level(sysref_level),
    .sample_in(sample_in), .sample_out(sample_out), .sysref_aligned(sysref_aligned),
    .sysref_marker_enable(sysref_marker_enable),
    .device_clock_pecl_mode(device_clock_pecl_mode), .sysref_pecl_mode(sysref_pecl_mode),
    .sysref_polarity_invert(sysref_polarity_invert), .feedback_gain_high(feedback_gain_high),
    .supply_noise_suppress(supply_noise_suppress), .sample_clock_delay(sample_clock_delay),
    .fullscale_range_chan_a(fullscale_range_chan_a));
`default_nettype wire

// File: tb/testbench.sv
/*
 * Self-checking testbench for the configuration register slice.
 * Assumes serial pins are driven on ref_clk rising edges, each serial clock half two cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic spi_csn = 1'b1;
    logic spi_sclk = 1'b0;
    logic spi_sdi = 1'b0;
    logic spi_sdo, spi_sdo_oe_n, sysref_aligned;
    logic [23:0] detector_position = 24'h5A3C96;
    logic sample_marking_enable = 1'b0;
    logic decimation_bypass = 1'b0;
    logic sysref_level = 1'b0;
    logic [11:0] sample_in = 12'hABC;
    logic [11:0] sample_out;
    logic marker, dev_pecl, sys_pecl, invert, gain, noise;
    logic [1:0] delay;
    logic [15:0] range;
    logic [23:0] rv;
    int fails = 0;
    int checks_done = 0;

    clk_sysref_cfg_regs #(.SAMPLE_W(12), .POS_W(24)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .spi_csn(spi_csn), .spi_sclk(spi_sclk),
        .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(spi_sdo_oe_n),
        .detector_position(detector_position), .sample_marking_enable(sample_marking_enable),
        .decimation_bypass(decimation_bypass), .sysref_level(sysref_level),
        .sample_in(sample_in), .sample_out(sample_out), .sysref_aligned(sysref_aligned),
        .sysref_marker_enable(marker), .device_clock_pecl_mode(dev_pecl),
        .sysref_pecl_mode(sys_pecl), .sysref_polarity_invert(invert),
        .feedback_gain_high(gain), .supply_noise_suppress(noise),
        .sample_clock_delay(delay), .fullscale_range_chan_a(range));

    // The 25 MHz reference clock.
    always #20 ref_clk = ~ref_clk;

    // Compares one value and counts the outcome.
    task chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task test_done;
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One serial frame: header, then nbits data bits, low byte first, MSB first.
    task automatic xfer(input logic rd, input logic [14:0] addr, input int nbits,
                        input logic [23:0] wdata);
        logic [15:0] hdr;
        int i;
        int j;
        hdr = {rd, addr};
        rv = 24'h000000;
        spi_csn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        for (i = 0; i < 16 + nbits; i++) begin
            j = i - 16;
            spi_sdi <= (i < 16) ? hdr[15 - i] : wdata[(j / 8) * 8 + 7 - j % 8];
            spi_sclk <= 1'b0;
            repeat (2) @(posedge ref_clk);
            // The bit is taken as the serial clock rises, before the next byte loads.
            if (i >= 16) begin
                rv[(j / 8) * 8 + 7 - j % 8] = spi_sdo;
            end
            spi_sclk <= 1'b1;
            repeat (2) @(posedge ref_clk);
        end
        spi_sclk <= 1'b0;
        repeat (2) @(posedge ref_clk);
        spi_csn <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask

    // Reads nb bytes from addr and compares them.
    task rd(input logic [14:0] addr, input int nb, input logic [23:0] exp);
        xfer(1'b1, addr, nb * 8, 24'h000000);
        chk(rv, exp);
    endtask

    // Applies reset for six cycles and checks the defaults through the port.
    task reset_check;
        rst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd(15'h002A, 1, 24'h000000);
        rd(15'h002B, 1, 24'h000011);
        rd(15'h0030, 2, 24'h00A000);
        chk({gain, noise, delay}, 24'h000009);
        chk({marker, dev_pecl, sys_pecl, invert}, 24'h000000);
    endtask

    // Cuts a hung run short.
    initial begin
        repeat (100000) @(posedge ref_clk);
        fails++;
        test_done;
    end

    // Main sequence.
    initial begin
        int i;
        reset_check;
        for (i = 0; i < 4; i++) begin
            xfer(1'b0, 15'h002A, 8, 24'h000001 << i);
            chk({marker, dev_pecl, sys_pecl, invert}, 24'h000001 << i);
        end
        xfer(1'b0, 15'h002A, 8, 24'h0000F5);
        rd(15'h002A, 1, 24'h0000F5);
        xfer(1'b0, 15'h002B, 8, 24'h000006);
        chk({gain, noise, delay}, 24'h000006);
        rd(15'h002B, 1, 24'h000006);
        xfer(1'b0, 15'h002B, 8, 24'h000011);
        chk({gain, noise, delay}, 24'h000009);
        xfer(1'b0, 15'h0030, 16, 24'h002000);
        chk(range, 24'h002000);
        xfer(1'b0, 15'h0030, 16, 24'h00FFFF);
        rd(15'h0030, 2, 24'h00FFFF);
        xfer(1'b0, 15'h0030, 4, 24'h000000);
        chk(range, 24'h00FFFF);
        xfer(1'b0, 15'h002C, 24, 24'h123456);
        rd(15'h002C, 3, 24'h5A3C96);
        detector_position <= 24'hC3A50F;
        repeat (3) @(posedge ref_clk);
        rd(15'h002C, 3, 24'hC3A50F);
        rd(15'h0040, 1, 24'h000000);
        // Inverted low SYSREF gives a marked LSB of one, unlike the sample's own LSB.
        xfer(1'b0, 15'h002A, 8, 24'h000009);
        sysref_level <= 1'b0;
        for (i = 0; i < 4; i++) begin
            decimation_bypass <= i[0];
            sample_marking_enable <= i[1];
            repeat (3) @(posedge ref_clk);
            chk(sample_out, (i == 3) ? 24'h000ABD : 24'h000ABC);
            chk(sysref_aligned, 24'h000001);
        end
        reset_check;
        test_done;
    end
endmodule
`default_nettype wire
